// >>> core/host_port_pkg.sv
package host_port_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_NS = 195;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam logic [4:0] TICK_LAST = 5'(TICK_CYCLES - 1);
	localparam logic [4:0] PHASE_A_AT = 5'h00;
	localparam logic [4:0] PHASE_B_AT = 5'(TICK_CYCLES / 2);
	localparam logic [4:0] PHASE_C_AT = 5'(TICK_CYCLES - 4);
	localparam logic [1:0] CODE_A = 2'h0;
	localparam logic [1:0] CODE_B = 2'h1;
	// condition-out A field positions
	localparam int ATICK_BIT = 16;
	localparam int RESET_BIT = 17;
	localparam int IRQ_A_LSB = 18;
	localparam int IRQ_B_LSB = 21;
	localparam int DIAG_GRP_LSB = 25;
	localparam int DIAG_HALF_BIT = 31;
	// condition-out B field positions
	localparam int LATCH_DATA_BIT = 31;
	localparam int LATCH_ADDR_LSB = 32;
	// condition latch mask positions
	localparam int IRQ_MASK_LO = 6;
	localparam int IRQ_MASK_HI_LSB = 8;
	localparam int CAP_MASK_LSB = 9;
	// capture register layout
	localparam int CAP_LOST_BIT = 5;
	localparam int CAP_TIME_LSB = 6;
	localparam logic [5:0] DIAG_ADDR_CAPTURE = 6'o15;
	localparam logic [5:0] DIAG_ADDR_LATCH = 6'o63;
	localparam logic [15:0] COND_RESET = 16'h0000;
endpackage

// >>> core/tick_phase_gen.sv
`timescale 1ns/1ps
`default_nettype none
module tick_phase_gen (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	output logic phase_a_o,
	output logic phase_b_o,
	output logic phase_c_o
);
	typedef struct packed {
		logic [4:0] cnt;
	} tick_t;
	tick_t st;
	tick_t next_st;
	always_comb begin
		next_st = st;
		if (st.cnt == host_port_pkg::TICK_LAST) begin
			next_st.cnt = 5'h00;
		end else begin
			next_st.cnt = st.cnt + 5'h01;
		end
	end
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign phase_a_o = (st.cnt == host_port_pkg::PHASE_A_AT);
	assign phase_b_o = (st.cnt == host_port_pkg::PHASE_B_AT);
	assign phase_c_o = (st.cnt == host_port_pkg::PHASE_C_AT);
endmodule
`default_nettype wire

// >>> core/host_io_bus_control_port.sv
`timescale 1ns/1ps
`default_nettype none
module host_io_bus_control_port (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [4:0] device_number_switches_i,
	input wire logic [4:0] bus_device_select_high_i,
	input wire logic [1:0] bus_device_select_low_i,
	input wire logic datai_i,
	input wire logic coni_i,
	input wire logic datao_clr_i,
	input wire logic cono_i,
	input wire logic [35:0] bus_data_i,
	input wire logic host_bus_reset_i,
	input wire logic power_on_reset_i,
	input wire logic write_buffer_done_i,
	input wire logic delay_transfer_done_i,
	input wire logic code_a_dataout_done_i,
	input wire logic address_table_write_i,
	input wire logic [4:0] event_bits_i,
	input wire logic [7:0] time_state_bits_i,
	input wire logic [7:0] irq_conditions_i,
	input wire logic [19:0] delay_out_i,
	input wire logic [19:0] diag_ext_i,
	output logic device_selected_o,
	output logic bus_driver_enable_o,
	output logic [19:0] bus_output_word_o,
	output logic dataout_clock_o,
	output logic code_a_selected_o,
	output logic code_b_selected_o,
	output logic dataout_pending_flag_o,
	output logic [2:0] irq_channel_a_number_o,
	output logic [2:0] irq_channel_b_number_o,
	output logic all_ticks_update_flag_o,
	output logic [15:0] condition_latch_bits_o,
	output logic master_reset_o,
	output logic [16:0] event_capture_register_o,
	output logic capture_frozen_o,
	output logic [7:0] irq_request_lines_o,
	output logic [63:0] diag_group_enables_o,
	output logic diag_half_select_o,
	output logic [19:0] diag_bus_o
);
	typedef struct packed {
		logic code_a;
		logic code_b;
		logic datao_sync;
		logic cono_a_sync;
		logic coni_b_sync;
		logic pending;
		logic [2:0] irq_a_num;
		logic [2:0] irq_b_num;
		logic [5:0] diag_grp;
		logic diag_half;
		logic all_ticks;
		logic reset_bit;
		logic atick_data;
		logic [15:0] cond;
		logic [16:0] capture;
		logic [7:0] irq;
		logic [19:0] out_word;
	} port_t;

	port_t st;
	port_t next_st;

	function automatic logic is_code(input logic [1:0] low,
		input logic [1:0] code);
		is_code = (low == code);
	endfunction

	logic phase_a;
	logic phase_b;
	logic phase_c;
	logic cono_a_strobe;
	logic cono_b_strobe;
	logic coni_b_strobe;
	logic any_done;
	logic [7:0] irq_mask;
	logic [7:0] masked_cond;
	logic req_a;
	logic req_b;
	logic cap_hit;
	logic new_hit;
	logic irq_clear;
	logic [19:0] diag_word;

	tick_phase_gen u_phase (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.phase_a_o(phase_a),
		.phase_b_o(phase_b),
		.phase_c_o(phase_c)
	);

	assign device_selected_o =
		(bus_device_select_high_i == device_number_switches_i);
	assign bus_driver_enable_o =
		device_selected_o & (datai_i | coni_i);
	assign dataout_clock_o = device_selected_o & datao_clr_i;
	assign cono_a_strobe = device_selected_o & cono_i &
		is_code(bus_device_select_low_i, host_port_pkg::CODE_A);
	assign cono_b_strobe = device_selected_o & cono_i &
		is_code(bus_device_select_low_i, host_port_pkg::CODE_B);
	assign coni_b_strobe = device_selected_o & coni_i &
		is_code(bus_device_select_low_i, host_port_pkg::CODE_B);
	assign any_done = write_buffer_done_i | delay_transfer_done_i |
		code_a_dataout_done_i | address_table_write_i;
	assign master_reset_o = host_bus_reset_i | power_on_reset_i |
		(st.cono_a_sync & st.reset_bit);

	assign irq_mask = {st.cond[14:host_port_pkg::IRQ_MASK_HI_LSB],
		st.cond[host_port_pkg::IRQ_MASK_LO]};
	assign masked_cond = irq_conditions_i & irq_mask;
	assign req_a = |masked_cond[3:0];
	assign req_b = |masked_cond[7:4];

	assign cap_hit = |(st.capture[4:0] &
		st.cond[host_port_pkg::CAP_MASK_LSB +: 5]);
	assign new_hit = |(event_bits_i &
		st.cond[host_port_pkg::CAP_MASK_LSB +: 5]);
	assign irq_clear = master_reset_o | st.datao_sync |
		st.cono_a_sync | cono_b_strobe;

	always_comb begin
		diag_word = diag_ext_i;
		if (st.diag_grp == host_port_pkg::DIAG_ADDR_CAPTURE) begin
			// low four positions carry nothing meaningful
			diag_word = {st.capture[4:0], st.capture[16:6], 4'h0};
		end else if (st.diag_grp == host_port_pkg::DIAG_ADDR_LATCH) begin
			diag_word = {st.cond, 4'h0};
		end
	end

	always_comb begin
		next_st = st;
		if (dataout_clock_o) begin
			next_st.code_a = is_code(bus_device_select_low_i,
				host_port_pkg::CODE_A);
			next_st.code_b = is_code(bus_device_select_low_i,
				host_port_pkg::CODE_B);
		end
		next_st.datao_sync = dataout_clock_o;
		next_st.cono_a_sync = cono_a_strobe;
		next_st.coni_b_sync = coni_b_strobe;
		if (any_done | master_reset_o) begin
			next_st.pending = 1'b0;
		end
		if (st.datao_sync) begin
			next_st.pending = 1'b1;
		end
		if (cono_a_strobe) begin
			next_st.irq_a_num =
				bus_data_i[host_port_pkg::IRQ_A_LSB +: 3];
			next_st.irq_b_num =
				bus_data_i[host_port_pkg::IRQ_B_LSB +: 3];
			next_st.diag_grp =
				bus_data_i[host_port_pkg::DIAG_GRP_LSB +: 6];
			next_st.diag_half =
				bus_data_i[host_port_pkg::DIAG_HALF_BIT];
			next_st.reset_bit = bus_data_i[host_port_pkg::RESET_BIT];
			// hold the flag bit until the synchronized strobe acts
			next_st.atick_data = bus_data_i[host_port_pkg::ATICK_BIT];
		end
		if (st.cono_a_sync) begin
			next_st.all_ticks = st.atick_data;
		end
		if (cono_b_strobe) begin
			next_st.cond[bus_data_i[host_port_pkg::LATCH_ADDR_LSB +: 4]] =
				bus_data_i[host_port_pkg::LATCH_DATA_BIT];
		end
		if (phase_c & ~cap_hit) begin
			next_st.capture[4:0] = event_bits_i;
			next_st.capture[13:6] = time_state_bits_i;
		end
		if (st.coni_b_sync) begin
			next_st.capture[host_port_pkg::CAP_LOST_BIT] = 1'b0;
		end
		if (phase_c & cap_hit & new_hit) begin
			next_st.capture[host_port_pkg::CAP_LOST_BIT] = 1'b1;
		end
		if (irq_clear) begin
			next_st.irq = 8'h00;
		end
		if (phase_a) begin
			next_st.irq[st.irq_a_num] = req_a;
		end
		if (phase_b) begin
			next_st.irq[st.irq_b_num] = req_b;
		end
		case ({coni_i, is_code(bus_device_select_low_i,
			host_port_pkg::CODE_B)})
			2'b00: next_st.out_word = diag_word;
			2'b01: next_st.out_word = delay_out_i;
			2'b10: next_st.out_word = {st.cond, st.pending, st.all_ticks,
				st.capture[host_port_pkg::CAP_LOST_BIT], cap_hit};
			2'b11: next_st.out_word = {3'h0, st.capture};
			default: next_st.out_word = 20'h00000;
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st <= '0;
			st.cond <= host_port_pkg::COND_RESET;
		end else begin
			st <= next_st;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 64; g++) begin : g_diag_en
			assign diag_group_enables_o[g] =
				(st.diag_grp == 6'(g));
		end
	endgenerate

	assign diag_half_select_o = st.diag_half;
	assign diag_bus_o = diag_word;
	assign bus_output_word_o = st.out_word;
	assign code_a_selected_o = st.code_a;
	assign code_b_selected_o = st.code_b;
	assign dataout_pending_flag_o = st.pending;
	assign irq_channel_a_number_o = st.irq_a_num;
	assign irq_channel_b_number_o = st.irq_b_num;
	assign all_ticks_update_flag_o = st.all_ticks;
	assign condition_latch_bits_o = st.cond;
	assign event_capture_register_o = st.capture;
	assign capture_frozen_o = cap_hit;
	assign irq_request_lines_o = st.irq;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_dataout;
		dataout_clock_o ##1 st.datao_sync;
	endsequence

	sequence s_frozen_hit;
		phase_c && cap_hit && new_hit;
	endsequence

	sequence s_cono_a;
		cono_a_strobe ##1 st.cono_a_sync;
	endsequence

	AST_SELECT: assert property (
		device_selected_o ==
		(bus_device_select_high_i == device_number_switches_i))
		else $error("select does not follow switch compare");

	AST_DRIVE: assert property (
		bus_driver_enable_o |-> device_selected_o && (datai_i || coni_i))
		else $error("bus drivers on without selected input transfer");

	AST_PENDING_SET: assert property (
		s_dataout |=> st.pending)
		else $error("pending flag not set after data-out");

	AST_PENDING_CLR: assert property (
		st.pending && any_done && !st.datao_sync |=> !st.pending)
		else $error("pending flag not cleared by completion");

	AST_IRQ_NUM: assert property (
		cono_a_strobe |=> irq_channel_a_number_o == $past(bus_data_i[20:18])
		&& irq_channel_b_number_o == $past(bus_data_i[23:21]))
		else $error("interrupt channel numbers not loaded");

	AST_DIAG_ADDR: assert property (
		cono_a_strobe |=> st.diag_grp == $past(bus_data_i[30:25])
		&& st.diag_half == $past(bus_data_i[31]))
		else $error("diagnostic address not loaded");

	AST_LATCH: assert property (
		cono_b_strobe |=> st.cond[$past(bus_data_i[35:32])] ==
		$past(bus_data_i[31]))
		else $error("condition latch cell not written");

	AST_RESET: assert property (
		(host_bus_reset_i || power_on_reset_i) |-> master_reset_o)
		else $error("master reset missing");

	AST_FROZEN: assert property (
		phase_c && cap_hit |=> $stable(st.capture[4:0])
		&& $stable(st.capture[13:6]))
		else $error("capture register loaded while frozen");

	AST_LOST: assert property (
		s_frozen_hit |=> st.capture[host_port_pkg::CAP_LOST_BIT])
		else $error("lost event bit not set");

	AST_IRQ_CLR: assert property (
		irq_clear && !phase_a && !phase_b |=> irq_request_lines_o == 8'h00)
		else $error("interrupt requests not cleared");

	AST_DIAG15: assert property (
		st.diag_grp == host_port_pkg::DIAG_ADDR_CAPTURE |->
		diag_bus_o[19:4] == {st.capture[4:0], st.capture[16:6]})
		else $error("capture readback wrong");

	AST_CODE_REG: assert property (
		dataout_clock_o |=> code_a_selected_o ==
		($past(bus_device_select_low_i) == host_port_pkg::CODE_A) &&
		code_b_selected_o ==
		($past(bus_device_select_low_i) == host_port_pkg::CODE_B))
		else $error("device code not registered on data-out clock");

	AST_SYNC_STAGE: assert property (
		(dataout_clock_o |=> st.datao_sync) and
		(coni_b_strobe |=> st.coni_b_sync))
		else $error("transfer not passed through sync stage");

	AST_ATICK: assert property (
		s_cono_a |=> all_ticks_update_flag_o ==
		$past(bus_data_i[host_port_pkg::ATICK_BIT], 2))
		else $error("all ticks flag not loaded from transfer");

	AST_RESET_BIT: assert property (
		cono_a_strobe && bus_data_i[host_port_pkg::RESET_BIT] |=>
		master_reset_o)
		else $error("reset bit did not raise master reset");

	AST_LOST_CLR: assert property (
		st.coni_b_sync && !(phase_c && cap_hit && new_hit) |=>
		!event_capture_register_o[host_port_pkg::CAP_LOST_BIT])
		else $error("lost event bit not cleared by read");

	AST_IRQ_A: assert property (
		phase_a |=>
		irq_request_lines_o[$past(st.irq_a_num)] == $past(req_a))
		else $error("group a request not written at channel a");

	AST_IRQ_B: assert property (
		phase_b |=>
		irq_request_lines_o[$past(st.irq_b_num)] == $past(req_b))
		else $error("group b request not written at channel b");

	AST_IRQ_GATE: assert property (
		phase_a && (irq_conditions_i[3:0] & {condition_latch_bits_o[10:8],
		condition_latch_bits_o[6]}) == 4'h0 |=>
		!irq_request_lines_o[$past(st.irq_a_num)])
		else $error("masked request raised");

	AST_GROUP_EN: assert property (
		$onehot(diag_group_enables_o) &&
		diag_group_enables_o[st.diag_grp])
		else $error("diagnostic group enable not one-hot");

	AST_OUT_DELAY: assert property (
		datai_i && !coni_i &&
		bus_device_select_low_i == host_port_pkg::CODE_B |=>
		bus_output_word_o == $past(delay_out_i))
		else $error("delay word not selected for data input");

	AST_OUT_CAPTURE: assert property (
		coni_i && bus_device_select_low_i == host_port_pkg::CODE_B |=>
		bus_output_word_o == {3'h0, $past(event_capture_register_o)})
		else $error("capture word not selected for condition input");
endmodule
`default_nettype wire

// >>> test/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
	input wire logic clk_i,
	output logic [4:0] sel_high_o,
	output logic [1:0] sel_low_o,
	output logic datai_o,
	output logic coni_o,
	output logic datao_clr_o,
	output logic cono_o,
	output logic [35:0] data_o
);
	initial begin
		{sel_high_o, sel_low_o, datai_o, coni_o, datao_clr_o, cono_o} = '0;
		data_o = '0;
	end
	// kind 0 cono, 1 datao, 2 datai, 3 coni; input kinds held two cycles
	task automatic xfer(input logic [1:0] kind, input logic [4:0] hi,
		input logic [1:0] lo, input logic [35:0] d);
		@(posedge clk_i);
		sel_high_o <= hi;
		sel_low_o <= lo;
		data_o <= d;
		cono_o <= (kind == 2'h0);
		datao_clr_o <= (kind == 2'h1);
		datai_o <= (kind == 2'h2);
		coni_o <= (kind == 2'h3);
		repeat (kind[1] ? 2 : 1) @(posedge clk_i);
		{datai_o, coni_o, datao_clr_o, cono_o} <= 4'h0;
		// released data and high select lines do not keep their last value; sel_low_o does
		data_o <= ~d;
		sel_high_o <= ~hi;
	endtask
endmodule
`default_nettype wire

// >>> test/host_io_bus_control_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module host_io_bus_control_port_tb;
	localparam logic [4:0] SW = 5'h0b;
	logic clk_i = 0, sys_rst_i = 1, host_rst = 0, por = 0;
	logic [3:0] done = 4'h0;
	logic [4:0] events = 5'h00, sel_hi;
	logic [7:0] conds = 8'h00, tstate = 8'h00, irq;
	logic [19:0] delay_out = 20'h5a3c1, bus_word, diag;
	logic [1:0] sel_lo;
	logic datai, coni, datao_clr, cono, dev_sel, drv_en, code_b, pending;
	logic atick, mrst, frozen, half, code_a, dclk;
	logic [35:0] bus_data;
	logic [2:0] irq_a, irq_b;
	logic [15:0] latch;
	logic [16:0] cap;
	logic [63:0] grp;
	int err_count = 0, cmp_count = 0;
	initial forever #4 clk_i = ~clk_i;
	host_bus_model u_host (.clk_i(clk_i), .sel_high_o(sel_hi),
		.sel_low_o(sel_lo), .datai_o(datai), .coni_o(coni),
		.datao_clr_o(datao_clr), .cono_o(cono), .data_o(bus_data));
	host_io_bus_control_port u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.device_number_switches_i(SW), .bus_device_select_high_i(sel_hi),
		.bus_device_select_low_i(sel_lo), .datai_i(datai), .coni_i(coni),
		.datao_clr_i(datao_clr), .cono_i(cono), .bus_data_i(bus_data),
		.host_bus_reset_i(host_rst), .power_on_reset_i(por),
		.write_buffer_done_i(done[0]), .delay_transfer_done_i(done[1]),
		.code_a_dataout_done_i(done[2]), .address_table_write_i(done[3]),
		.event_bits_i(events), .time_state_bits_i(tstate),
		.irq_conditions_i(conds), .delay_out_i(delay_out),
		.diag_ext_i(20'h0f0f0), .device_selected_o(dev_sel),
		.bus_driver_enable_o(drv_en), .bus_output_word_o(bus_word),
		.dataout_clock_o(dclk), .code_a_selected_o(code_a),
		.code_b_selected_o(code_b),
		.dataout_pending_flag_o(pending), .irq_channel_a_number_o(irq_a),
		.irq_channel_b_number_o(irq_b), .all_ticks_update_flag_o(atick),
		.condition_latch_bits_o(latch), .master_reset_o(mrst),
		.event_capture_register_o(cap), .capture_frozen_o(frozen),
		.irq_request_lines_o(irq), .diag_group_enables_o(grp),
		.diag_half_select_o(half), .diag_bus_o(diag));
	task automatic chk(input logic [63:0] got, exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic xf(input logic [1:0] kind, lo, input logic [35:0] d);
		u_host.xfer(kind, SW, lo, d);
		wait_n(3);
	endtask
	task automatic rd(input logic [1:0] kind, lo,
		input logic [19:0] exp, msk, input string m);
		fork
			u_host.xfer(kind, SW, lo, 36'h0);
			begin
				wait_n(2);
				chk(bus_word & msk, exp & msk, m);
			end
		join
		wait_n(1);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic t_cono_a;
		xf(2'h0, 2'h0, 36'h0_9a75_0000);
		chk(irq_a, 3'h5, "irq channel a");
		chk(irq_b, 3'h3, "irq channel b");
		chk(grp, 64'h1 << 13, "diag group enable");
		chk(half, 1'b1, "diag half");
		chk(atick, 1'b1, "all ticks flag");
	endtask
	task automatic t_latch;
		xf(2'h0, 2'h1, 36'h9_8000_0000);
		chk(latch, 16'h0200, "latch cell write");
		u_host.xfer(2'h0, SW ^ 5'h01, 2'h1, 36'ha_8000_0000);
		wait_n(3);
		chk(latch, 16'h0200, "write while unselected");
		xf(2'h0, 2'h1, 36'h6_8000_0000);
		chk(latch, 16'h0240, "second cell write");
	endtask
	task automatic t_datao;
		for (int i = 0; i < 4; i++) begin
			xf(2'h1, {1'b0, i[0]}, 36'h0);
			chk(code_a, !i[0], "code a select");
			chk(code_b, i[0], "code b select");
			chk(pending, 1'b1, "pending set");
			@(posedge clk_i) done[i] <= 1'b1;
			@(posedge clk_i) done[i] <= 1'b0;
			wait_n(2);
			chk(pending, 1'b0, "pending cleared");
		end
	endtask
	task automatic t_irq;
		@(posedge clk_i) conds <= 8'h01;
		wait_n(30);
		chk(irq, 8'h20, "request on channel a");
		xf(2'h0, 2'h1, 36'h6_0000_0000);
		wait_n(30);
		chk(irq, 8'h00, "masked request");
		@(posedge clk_i) conds <= 8'h00;
	endtask
	task automatic t_capture;
		int n = 0;
		@(posedge clk_i) tstate <= 8'ha5;
		events <= 5'h01;
		while (!frozen && n < 30) begin
			wait_n(1);
			n++;
		end
		chk(frozen, 1'b1, "capture frozen");
		chk(cap, {3'h0, 8'ha5, 1'b0, 5'h01}, "capture content");
		chk(diag[19:4], {5'h01, 11'h0a5}, "readback");
		@(posedge clk_i) tstate <= 8'h3c;
		wait_n(30);
		chk(cap[5], 1'b1, "lost event");
		chk(cap[13:6], 8'ha5, "no reload while frozen");
		@(posedge clk_i) events <= 5'h00;
		rd(2'h3, 2'h1, 20'h02961, 20'hfffff, "capture word");
		chk(cap[5], 1'b0, "lost cleared by read");
	endtask
	task automatic t_datai;
		fork
			u_host.xfer(2'h2, SW, 2'h1, 36'h0);
			begin
				wait_n(1);
				chk(drv_en, 1'b1, "driver enable");
				chk(dev_sel, 1'b1, "device selected");
				wait_n(1);
				chk(bus_word, delay_out, "delay word");
			end
		join
		wait_n(1);
		chk(drv_en, 1'b0, "driver released");
		chk(dev_sel, 1'b0, "deselected after release");
		rd(2'h2, 2'h0, 20'h08a50, 20'hffff0, "diag word");
		rd(2'h3, 2'h0, 20'h02005, 20'hfffff, "condition word");
	endtask
	task automatic t_reset;
		@(posedge clk_i) host_rst <= 1'b1;
		wait_n(1);
		chk(mrst, 1'b1, "bus reset");
		@(posedge clk_i) host_rst <= 1'b0;
		por <= 1'b1;
		wait_n(1);
		chk(mrst, 1'b1, "power on reset");
		@(posedge clk_i) por <= 1'b0;
		wait_n(1);
		chk(mrst, 1'b0, "reset released");
		fork
			u_host.xfer(2'h1, SW, 2'h0, 36'h0);
			begin
				wait_n(1);
				chk(dclk, 1'b1, "data-out clock");
				wait_n(1);
				chk(pending, 1'b0, "pending before sync stage");
				wait_n(1);
				chk(pending, 1'b1, "pending after sync stage");
			end
		join
		fork
			u_host.xfer(2'h0, SW, 2'h0, 36'h0_9a77_0000);
			begin
				wait_n(2);
				chk(mrst, 1'b1, "reset bit of condition-out");
				wait_n(1);
				chk(mrst, 1'b0, "reset bit pulse ends");
			end
		join
		chk(pending, 1'b0, "pending cleared by master reset");
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		$display("unexpected at %0t: timeout", $time);
		complete_run();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		wait_n(2);
		t_cono_a();
		t_latch();
		t_datao();
		t_irq();
		t_capture();
		t_datai();
		t_reset();
		complete_run();
	end
endmodule
`default_nettype wire
